/* File: design/dmb_banking.sv */
// Data-memory address formation, banking and shared USB banks.
// Assumes an executor aligned to phase_o and a serial engine on clk_sys_i.
`timescale 1ns/10ps
module dmb_banking #(
  parameter int NUM_BANKS = 8 // Implemented banks from bank 0 upward.
) (
  input wire logic clk_sys_i, // System clock, 125 MHz.
  input wire logic rst_n_i, // Asynchronous reset, active low.
  input wire dmb_pkg::dmb_exe_req_t exe_i, // Executor request.
  output dmb_pkg::dmb_phase_t phase_o, // Current Q phase.
  output logic [7:0] core_rdata_o, // Operand read in Q2.
  output logic [11:0] lit_o, // Consumed second-word literal.
  output logic lit_valid_o, // Literal belongs to this cycle.
  output logic nop_o, // Lone second word, no-operation.
  output logic [7:0] pc_low_o, // Program counter low byte.
  output logic pc_low_wr_o, // Pulse when it was written.
  input wire dmb_pkg::dmb_reg_req_t reg_i, // Register port request.
  output logic [7:0] reg_rdata_o, // Register read data.
  input wire dmb_pkg::dmb_usb_req_t usb_i, // Serial engine request.
  output logic [7:0] usb_rdata_o // Serial engine read data.
);
  import dmb_pkg::*;

  localparam int MEM_N = NUM_BANKS * (2 ** OFF_W);

  dmb_phase_t phase;
  logic [15:0] ir;
  logic ir_valid;
  logic ir_rd;
  logic pend_two;
  logic pend_move;
  logic second_ok;
  logic second_mv;
  logic [3:0] bank_ptr;
  logic usb_en;
  logic [7:0] move_data;
  logic [7:0] mem [MEM_N];
  logic [11:0] eff_addr;
  logic [7:0] eff_rdata;
  logic eff_impl;
  logic is_second;
  logic is_move;
  logic is_two;
  logic is_banklit;
  logic core_we;
  logic [7:0] core_wdata;
  logic usb_hit;
  logic [11:0] usb_full;

  // Decode of the word presented by the executor.
  assign is_second = exe_i.word[15:12] == SECOND_TAG;
  assign is_move = exe_i.word[15:12] == MOVE_TAG;
  assign is_two = is_move || exe_i.word[15:9] == CALL_TAG
    || exe_i.word[15:8] == GOTO_TAG || exe_i.word[15:6] == PTRLIT_TAG;
  assign is_banklit = exe_i.word[15:4] == BANKLIT_TAG;

  // Four-phase instruction cycle ring.
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      phase <= DMB_Q1;
    end else begin
      case (phase)
        DMB_Q1: phase <= DMB_Q2;
        DMB_Q2: phase <= DMB_Q3;
        DMB_Q3: phase <= DMB_Q4;
        DMB_Q4: phase <= DMB_Q1;
        default: phase <= DMB_Q1;
      endcase
    end
  end
  assign phase_o = phase;

  // Latch the instruction at Q1 and track two-word sequencing.
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ir <= 16'h0000;
      ir_valid <= 1'b0;
      ir_rd <= 1'b0;
      pend_two <= 1'b0;
      pend_move <= 1'b0;
      second_ok <= 1'b0;
      second_mv <= 1'b0;
    end else if (phase == DMB_Q1) begin
      ir <= exe_i.word;
      ir_valid <= exe_i.valid;
      ir_rd <= exe_i.mem_rd;
      second_ok <= exe_i.valid && is_second && pend_two;
      // The move flag is taken from the previous word before it is cleared.
      second_mv <= exe_i.valid && is_second && pend_move;
      pend_two <= exe_i.valid && is_two;
      pend_move <= exe_i.valid && is_move;
    end
  end

  // Literal and no-operation flags for the current instruction cycle.
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      lit_o <= 12'h000;
      lit_valid_o <= 1'b0;
      nop_o <= 1'b0;
    end else if (phase == DMB_Q1) begin
      lit_o <= exe_i.word[11:0];
      lit_valid_o <= exe_i.valid && is_second && pend_two;
      nop_o <= exe_i.valid && is_second && !pend_two;
    end
  end

  // Effective address: full move address, banked, or fast-access map.
  always_comb begin
    if (ir[15:12] == MOVE_TAG || second_mv) begin
      eff_addr = ir[11:0];
    end else if (ir[ACC_BIT]) begin
      eff_addr = {bank_ptr, ir[7:0]};
    end else if (ir[7:0] < ACC_SPLIT) begin
      eff_addr = {ACC_LO_BANK, ir[7:0]};
    end else begin
      eff_addr = {ACC_HI_BANK, ir[7:0]};
    end
  end

  // Read path; locations outside the implemented banks read as zero, except the program counter low byte.
  always_comb begin
    eff_impl = 32'(eff_addr[11:8]) < NUM_BANKS;
    if (eff_impl) begin
      eff_rdata = mem[eff_addr[$clog2(MEM_N)-1:0]];
    end else if (eff_addr == PC_LOW_ADDR) begin
      eff_rdata = pc_low_o;
    end else begin
      eff_rdata = BYTE_ZERO;
    end
  end

  // Operand read in Q2, also capturing the move source.
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      core_rdata_o <= BYTE_ZERO;
      move_data <= BYTE_ZERO;
    end else if (phase == DMB_Q2 && ir_valid) begin
      if (ir[15:12] == MOVE_TAG) begin
        move_data <= eff_rdata;
      end else if (ir_rd && !is_second_ir()) begin
        core_rdata_o <= eff_rdata;
      end
    end
  end

  function automatic logic is_second_ir();
    return ir[15:12] == SECOND_TAG;
  endfunction

  // Destination write in Q4; a lone second word writes nothing.
  always_comb begin
    core_we = 1'b0;
    core_wdata = exe_i.wdata;
    if (phase == DMB_Q4 && ir_valid) begin
      if (second_mv) begin
        core_we = 1'b1;
        core_wdata = move_data;
      end else if (!is_second_ir() && ir[15:12] != MOVE_TAG) begin
        core_we = exe_i.mem_wr;
      end
    end
  end

  // Engine access lands in banks 4-7 only while USB is enabled.
  assign usb_full = {USB_FIRST, 8'h00} + {2'b00, usb_i.addr};
  assign usb_hit = usb_en && 32'(usb_full[11:8]) < NUM_BANKS;

  // Dual-port storage; core writes take priority on a collision.
  always_ff @(posedge clk_sys_i) begin
    if (core_we && eff_impl) begin
      mem[eff_addr[$clog2(MEM_N)-1:0]] <= core_wdata;
    end
    if (usb_hit && usb_i.wr
        && !(core_we && eff_impl && eff_addr == usb_full)) begin
      mem[usb_full[$clog2(MEM_N)-1:0]] <= usb_i.wdata;
    end
  end

  // Engine read data, zero while the function is off.
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      usb_rdata_o <= BYTE_ZERO;
    end else if (usb_i.rd) begin
      usb_rdata_o <= usb_hit ? mem[usb_full[$clog2(MEM_N)-1:0]]
        : BYTE_ZERO;
    end
  end

  // Program counter low byte, reachable through bank 15.
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      pc_low_o <= BYTE_ZERO;
      pc_low_wr_o <= 1'b0;
    end else begin
      pc_low_wr_o <= core_we && eff_addr == PC_LOW_ADDR;
      if (core_we && eff_addr == PC_LOW_ADDR) begin
        pc_low_o <= core_wdata;
      end
    end
  end

  // Bank pointer: load-bank-literal wins over a port write.
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      bank_ptr <= BANK_PTR_RST;
    end else if (phase == DMB_Q1 && exe_i.valid && is_banklit
                 && !pend_two) begin
      bank_ptr <= exe_i.word[3:0];
    end else if (reg_i.wr && reg_i.addr == REG_BANK_PTR) begin
      bank_ptr <= reg_i.wdata[3:0];
    end
  end

  // Control register: USB function enable.
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      usb_en <= 1'b0;
    end else if (reg_i.wr && reg_i.addr == REG_CTRL) begin
      usb_en <= reg_i.wdata[CTRL_USB_BIT];
    end
  end

  // Register read data, one cycle after the read strobe.
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      reg_rdata_o <= BYTE_ZERO;
    end else if (reg_i.rd) begin
      case (reg_i.addr)
        REG_BANK_PTR: reg_rdata_o <= {NIB_ZERO, bank_ptr};
        REG_CTRL: reg_rdata_o <= {7'h00, usb_en};
        REG_STATUS: reg_rdata_o <= {6'h00, pend_move, pend_two};
        default: reg_rdata_o <= BYTE_ZERO;
      endcase
    end else begin
      reg_rdata_o <= BYTE_ZERO;
    end
  end

  // Checks on the behaviour above.
  phase_ring_a: assert property (
    @(posedge clk_sys_i) disable iff (!rst_n_i)
    phase == DMB_Q4 |=> phase == DMB_Q1 ##3 phase == DMB_Q4)
    else $error("Phase ring broken.");
  lone_nop_a: assert property (
    @(posedge clk_sys_i) disable iff (!rst_n_i)
    (phase == DMB_Q1 && exe_i.valid && is_second && !pend_two)
    |=> nop_o && !lit_valid_o ##2 !core_we)
    else $error("Lone second word did not act as no-operation.");
  pair_lit_a: assert property (
    @(posedge clk_sys_i) disable iff (!rst_n_i)
    (phase == DMB_Q1 && exe_i.valid && is_two) ##4
    (exe_i.valid && is_second) |=> lit_valid_o)
    else $error("Second word literal not consumed.");
  ptr_upper_a: assert property (
    @(posedge clk_sys_i) disable iff (!rst_n_i)
    reg_i.rd && reg_i.addr == REG_BANK_PTR |=> reg_rdata_o[7:4] == 4'h0)
    else $error("Bank pointer upper bits not zero.");
  bank_load_a: assert property (
    @(posedge clk_sys_i) disable iff (!rst_n_i)
    phase == DMB_Q1 && exe_i.valid && is_banklit && !pend_two
    |=> bank_ptr == $past(exe_i.word[3:0]))
    else $error("Bank literal not loaded.");
  banked_addr_a: assert property (
    @(posedge clk_sys_i) disable iff (!rst_n_i)
    phase == DMB_Q2 && ir[ACC_BIT] && ir[15:12] != MOVE_TAG && !second_ok
    |-> eff_addr == {bank_ptr, ir[7:0]})
    else $error("Banked address wrong.");
  fast_map_a: assert property (
    @(posedge clk_sys_i) disable iff (!rst_n_i)
    phase == DMB_Q2 && !ir[ACC_BIT] && ir[15:12] != MOVE_TAG && !second_ok
    |-> eff_addr[11:8] == (ir[7:0] < ACC_SPLIT ? 4'h0 : 4'hF))
    else $error("Fast-access mapping wrong.");
  unimpl_rd_a: assert property (
    @(posedge clk_sys_i) disable iff (!rst_n_i)
    phase == DMB_Q2 && ir_valid && ir_rd && ir[15:12] < 4'hC && !eff_impl
    && eff_addr != PC_LOW_ADDR |=> core_rdata_o == 8'h00)
    else $error("Unimplemented read not zero.");
  pc_low_a: assert property (
    @(posedge clk_sys_i) disable iff (!rst_n_i)
    core_we && eff_addr == PC_LOW_ADDR
    |=> pc_low_wr_o && pc_low_o == $past(core_wdata))
    else $error("Program counter low byte not written.");
  usb_off_a: assert property (
    @(posedge clk_sys_i) disable iff (!rst_n_i)
    !usb_en && usb_i.rd |=> usb_rdata_o == 8'h00)
    else $error("Engine read while disabled.");
  move_dst_a: assert property (
    @(posedge clk_sys_i) disable iff (!rst_n_i)
    core_we && second_mv |-> eff_addr == ir[11:0])
    else $error("Move destination used the bank pointer.");
endmodule

/* File: design/dmb_pkg.sv */
// Package for the data-memory banking block: constants, phases, carriers.
// Assumes a core that runs four clocks per instruction cycle.
package dmb_pkg;
  // Address widths.
  localparam int ADDR_W = 12;
  localparam int OFF_W = 8;
  localparam int BANK_W = 4;
  localparam int WORD_W = 16;
  localparam int USB_AW = 10;
  localparam int ACC_BIT = 8;
  // Opcode tags used to spot two-word instructions, their second words and load-bank-literal.
  localparam logic [3:0] SECOND_TAG = 4'hF;
  localparam logic [3:0] MOVE_TAG = 4'hC;
  localparam logic [6:0] CALL_TAG = 7'h76;
  localparam logic [7:0] GOTO_TAG = 8'hEF;
  localparam logic [9:0] PTRLIT_TAG = 10'h3B8;
  localparam logic [11:0] BANKLIT_TAG = 12'h010;
  // Fast-access map split and banks.
  localparam logic [7:0] ACC_SPLIT = 8'h60;
  localparam logic [3:0] ACC_LO_BANK = 4'h0;
  localparam logic [3:0] ACC_HI_BANK = 4'hF;
  localparam logic [3:0] USB_FIRST = 4'h4;
  localparam logic [11:0] PC_LOW_ADDR = 12'hFF9;
  // Register port map.
  localparam int REG_AW = 2;
  localparam logic [1:0] REG_BANK_PTR = 2'h0;
  localparam logic [1:0] REG_CTRL = 2'h1;
  localparam logic [1:0] REG_STATUS = 2'h2;
  localparam logic [3:0] BANK_PTR_RST = 4'h0;
  localparam logic [3:0] NIB_ZERO = 4'h0;
  localparam logic [7:0] BYTE_ZERO = 8'h00;
  localparam int CTRL_USB_BIT = 0;
  // Instruction-cycle phases.
  typedef enum logic [3:0] {
    DMB_Q1 = 4'b0001,
    DMB_Q2 = 4'b0010,
    DMB_Q3 = 4'b0100,
    DMB_Q4 = 4'b1000
  } dmb_phase_t;
  // Executor request, held for a whole instruction cycle.
  typedef struct packed {
    logic valid;
    logic [15:0] word;
    logic mem_rd;
    logic mem_wr;
    logic [7:0] wdata;
  } dmb_exe_req_t;
  // Register port request.
  typedef struct packed {
    logic [1:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } dmb_reg_req_t;
  // Serial engine request into the shared banks.
  typedef struct packed {
    logic rd;
    logic wr;
    logic [9:0] addr;
    logic [7:0] wdata;
  } dmb_usb_req_t;
endpackage

/* File: test/dmb_usb_engine.sv */
// Serial engine model: single reads and writes into the shared banks.
// Assumes the bank block answers a read on the clock after the strobe.
`timescale 1ns/10ps
module dmb_usb_engine (
  input wire logic clk_sys_i, // System clock.
  input wire logic rst_n_i, // Asynchronous reset, active low.
  input wire logic go_i, // Start one access.
  input wire logic wr_i, // Access is a write.
  input wire logic [9:0] addr_i, // Offset within the shared banks.
  input wire logic [7:0] wdata_i, // Write data.
  output dmb_pkg::dmb_usb_req_t req_o, // Request to the bank block.
  input wire logic [7:0] rdata_i, // Read data from the bank block.
  output logic [7:0] rdata_o // Captured read data.
);
  import dmb_pkg::*;
  logic rd_q;
  // Strobes last one cycle; idle address and data churn on purpose.
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      req_o <= '0;
    end else if (go_i) begin
      req_o <= {~wr_i, wr_i, addr_i, wdata_i};
    end else begin
      req_o <= {2'b00, ~req_o.addr, ~req_o.wdata};
    end
  end
  // Takes read data in the cycle after the read strobe.
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rd_q <= 1'b0;
      rdata_o <= 8'h00;
    end else begin
      rd_q <= req_o.rd;
      if (rd_q) begin
        rdata_o <= rdata_i;
      end
    end
  end
endmodule

/* File: test/tb_top.sv */
// Testbench for the data-memory banking block: scenarios and verdict.
// Assumes the package, the design and the engine model come first.
`timescale 1ns/10ps
module tb_top;
  import dmb_pkg::*;
  logic clk_sys_i, rst_n_i, go, go_wr, lv_w, nop_w, c_lv, c_nop, pcw_w;
  logic [9:0] go_addr;
  logic [7:0] go_data, eng_rd, core_w, pcl_w, rrd_w, urd_w, c_rd;
  logic [11:0] lit_w, c_lit;
  logic [15:0] firsts [3] = '{{GOTO_TAG, 8'h03}, {CALL_TAG, 9'h000},
    {PTRLIT_TAG, 6'h00}};
  dmb_exe_req_t exe_i;
  dmb_reg_req_t reg_i;
  dmb_usb_req_t usb_i;
  dmb_phase_t phase;
  int mismatches = 0;
  int comparisons = 0;
  int cycles = 0;
  int pcw_n = 0;
  dmb_banking uut (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .exe_i(exe_i),
    .phase_o(phase), .core_rdata_o(core_w), .lit_o(lit_w),
    .lit_valid_o(lv_w), .nop_o(nop_w), .pc_low_o(pcl_w), .pc_low_wr_o(pcw_w),
    .reg_i(reg_i), .reg_rdata_o(rrd_w), .usb_i(usb_i), .usb_rdata_o(urd_w));
  dmb_usb_engine eng (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .go_i(go),
    .wr_i(go_wr), .addr_i(go_addr), .wdata_i(go_data), .req_o(usb_i),
    .rdata_i(urd_w), .rdata_o(eng_rd));
  // Makes the 125 MHz clock.
  initial begin
    clk_sys_i = 1'b0;
    forever #4 clk_sys_i = ~clk_sys_i;
  end
  task check(input logic [11:0] seen, input logic [11:0] exp);
    comparisons++;
    if (seen !== exp) begin
      mismatches++;
      $display("wrong value at %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask
  task report_and_stop;
    $display("comparisons %0d, mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  // Waits for a Q4 edge, after which an instruction word may be offered.
  task sync;
    @(negedge clk_sys_i);
    while (phase !== DMB_Q4) @(negedge clk_sys_i);
    @(posedge clk_sys_i);
  endtask
  // Holds one word for a whole instruction cycle and samples its results.
  task exec(input logic [15:0] w, input logic rd, input logic wr,
            input logic [7:0] wd);
    exe_i <= {1'b1, w, rd, wr, wd};
    repeat (2) @(posedge clk_sys_i);
    @(negedge clk_sys_i);
    c_rd = core_w;
    c_lit = lit_w;
    c_lv = lv_w;
    c_nop = nop_w;
    repeat (2) @(posedge clk_sys_i);
  endtask
  task set_bank(input logic [3:0] k);
    exec({BANKLIT_TAG, k}, 1'b0, 1'b0, 8'h00);
  endtask
  task wr_mem(input logic a, input logic [7:0] off, input logic [7:0] d);
    exec({7'h37, a, off}, 1'b0, 1'b1, d);
  endtask
  task rd_mem(input logic a, input logic [7:0] off, input logic [7:0] exp);
    exec({7'h37, a, off}, 1'b1, 1'b0, 8'h00);
    check(c_rd, exp);
  endtask
  // One register port access; read data are taken in the following cycle.
  task reg_acc(input logic [1:0] a, input logic wr, input logic [7:0] d);
    @(posedge clk_sys_i);
    reg_i <= {a, d, wr, ~wr};
    @(posedge clk_sys_i);
    reg_i <= '0;
    @(negedge clk_sys_i);
  endtask
  // One engine access; read data are in eng_rd when this returns.
  task eng_acc(input logic wr, input logic [9:0] a, input logic [7:0] d);
    @(posedge clk_sys_i);
    go <= 1'b1;
    go_wr <= wr;
    go_addr <= a;
    go_data <= d;
    @(posedge clk_sys_i);
    go <= 1'b0;
    repeat (2) @(posedge clk_sys_i);
    @(negedge clk_sys_i);
  endtask
  task regs_test;
    reg_acc(REG_BANK_PTR, 1'b0, 8'h00);
    check(rrd_w, {NIB_ZERO, BANK_PTR_RST});
    reg_acc(REG_BANK_PTR, 1'b1, 8'hA5);
    reg_acc(REG_BANK_PTR, 1'b0, 8'h00);
    check(rrd_w, 8'h05);
    reg_acc(2'h3, 1'b0, 8'h00);
    check(rrd_w, 8'h00);
  endtask
  task bank_test;
    sync;
    set_bank(4'h1);
    wr_mem(1'b1, 8'h34, 8'h11);
    set_bank(4'h2);
    wr_mem(1'b1, 8'h34, 8'h22);
    set_bank(4'h0);
    wr_mem(1'b1, 8'h10, 8'h5A);
    set_bank(4'h9);
    wr_mem(1'b1, 8'h10, 8'h77);
    rd_mem(1'b1, 8'h10, 8'h00);
    rd_mem(1'b0, 8'h10, 8'h5A);
    wr_mem(1'b0, 8'hF9, 8'h4D);
    set_bank(4'hF);
    check(pcl_w, 8'h4D);
    wr_mem(1'b1, 8'hF9, 8'h3C);
    rd_mem(1'b1, 8'h80, 8'h00);
    check(pcl_w, 8'h3C);
    check(12'(pcw_n), 12'h002);
    set_bank(4'h1);
    rd_mem(1'b1, 8'h34, 8'h11);
    set_bank(4'h2);
    rd_mem(1'b1, 8'h34, 8'h22);
    exe_i <= '0;
    reg_acc(REG_BANK_PTR, 1'b0, 8'h00);
    check(rrd_w, 8'h02);
  endtask
  task move_test;
    sync;
    set_bank(4'h9);
    exec({MOVE_TAG, 12'h134}, 1'b1, 1'b0, 8'h00);
    check(c_rd, 8'h22);
    exec({SECOND_TAG, 12'h256}, 1'b0, 1'b0, 8'h00);
    check(c_lv, 1'b1);
    check(c_lit, 12'h256);
    check(c_nop, 1'b0);
    set_bank(4'h2);
    exec({SECOND_TAG, 12'h134}, 1'b0, 1'b0, 8'h00);
    check(c_nop, 1'b1);
    check(c_lv, 1'b0);
    rd_mem(1'b1, 8'h56, 8'h11);
    set_bank(4'h1);
    rd_mem(1'b1, 8'h34, 8'h11);
    foreach (firsts[i]) begin
      exec(firsts[i], 1'b0, 1'b0, 8'h00);
      exec({SECOND_TAG, 12'hABC}, 1'b0, 1'b0, 8'h00);
      check(c_lv, 1'b1);
      check(c_lit, 12'hABC);
    end
    exe_i <= '0;
  endtask
  task usb_test;
    sync;
    set_bank(4'h5);
    wr_mem(1'b1, 8'h10, 8'h99);
    rd_mem(1'b1, 8'h10, 8'h99);
    exe_i <= '0;
    eng_acc(1'b0, 10'h110, 8'h00);
    check(eng_rd, 8'h00);
    reg_acc(REG_CTRL, 1'b1, 8'h01);
    reg_acc(REG_CTRL, 1'b0, 8'h00);
    check(rrd_w, 8'h01);
    eng_acc(1'b0, 10'h110, 8'h00);
    check(eng_rd, 8'h99);
    eng_acc(1'b1, 10'h120, 8'h66);
    sync;
    rd_mem(1'b1, 8'h20, 8'h66);
    exe_i <= '0;
  endtask
  // Counts program counter low byte write pulses.
  always @(posedge clk_sys_i) begin
    if (pcw_w === 1'b1) begin
      pcw_n <= pcw_n + 1;
    end
  end
  // Cuts a hung run short.
  always @(posedge clk_sys_i) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      mismatches++;
      report_and_stop;
    end
  end
  // Resets the block, then runs every scenario in turn.
  initial begin
    rst_n_i = 1'b0;
    exe_i = '0;
    reg_i = '0;
    go = 1'b0;
    go_wr = 1'b0;
    go_addr = '0;
    go_data = '0;
    repeat (12) @(posedge clk_sys_i);
    rst_n_i <= 1'b1;
    regs_test;
    bank_test;
    move_test;
    usb_test;
    report_and_stop;
  end
endmodule
